// File: slt_bank.sv
// Register bank for lane test patterns, alignment identifier, end-of-frame comma and link status.
// Assumes the lane logic runs on CLOCK and that the sync and lock inputs arrive from pins.
`timescale 1ns/1ps

module slt_bank (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [9:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic LINK_UP,
    input wire logic SYNC_N_PIN,
    input wire logic PLL_LOCK_PIN,
    input wire logic SYSREF_REALIGN,
    input wire logic SYSREF_EVENT,
    input wire logic ILA_ACTIVE,
    input wire logic [1:0] ILA_MULTIFRAME,
    input wire logic FRAME_END_OK,
    output logic LINK_ENABLE,
    output slt_pkg::slt_pattern_t LANE_PATTERN,
    output logic LANE_STATIC,
    output logic [15:0] LANE_WORD,
    output slt_pkg::slt_ila_t ILA,
    output slt_pkg::slt_eof_t EOF,
    output logic IRQ
);
    import slt_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Maps a selector to a lane pattern, dropping reserved and unsupported codes.
    function automatic slt_pattern_t decode_pattern(input logic [4:0] sel, input logic is_8b10b);
        slt_pattern_t mode;
        mode = PAT_NORMAL;
        unique case (sel)
            5'h01: mode = PAT_PRBS7;
            5'h02: mode = PAT_PRBS15;
            5'h03: mode = PAT_PRBS23;
            5'h0D: mode = PAT_PRBS9;
            5'h0E: mode = PAT_PRBS31;
            5'h04: mode = PAT_RAMP;
            5'h05: mode = PAT_TRANSPORT;
            5'h06: mode = PAT_D21_5;
            5'h07: mode = is_8b10b ? PAT_K28_5 : PAT_NORMAL;
            5'h08: mode = is_8b10b ? PAT_REPEAT_ILA : PAT_NORMAL;
            5'h09: mode = is_8b10b ? PAT_MOD_RPAT : PAT_NORMAL;
            5'h10: mode = is_8b10b ? PAT_K28_7 : PAT_NORMAL;
            5'h0A: mode = PAT_HOLD_LOW;
            5'h0B: mode = PAT_HOLD_HIGH;
            5'h0F: mode = PAT_CLOCK;
            default: mode = PAT_NORMAL;
        endcase
        return mode;
    endfunction : decode_pattern

    // Gives the fixed lane word for the static patterns.
    function automatic logic [15:0] static_word(input slt_pattern_t mode);
        logic [15:0] word;
        word = WORD_LOW;
        if (mode == PAT_HOLD_HIGH) begin
            word = WORD_HIGH;
        end else if (mode == PAT_CLOCK) begin
            word = WORD_CLOCK;
        end
        return word;
    endfunction : static_word

    // Picks the comma; the reserved code falls back to the compliant K28.7.
    function automatic logic [7:0] eof_char(input logic [1:0] sel);
        logic [7:0] code;
        code = CHAR_K28_7;
        if (sel == 2'h1) begin
            code = CHAR_K28_1;
        end else if (sel == 2'h2) begin
            code = CHAR_K28_5;
        end
        return code;
    endfunction : eof_char

    // ************************************************************
    // State and pin synchronisation
    // ************************************************************
    slt_state_t state;
    slt_state_t next_state;
    logic [1:0] pins_sync;
    logic sync_level;
    logic pll_level;
    logic [7:0] status_byte;
    logic wr_status;

    // Sync request and PLL lock come from pins, so they are retimed first.
    slt_sync u_sync (
        .CLOCK(CLOCK),
        .RESET(RESET),
        .PIN_IN({PLL_LOCK_PIN, SYNC_N_PIN}),
        .PIN_OUT(pins_sync)
    );

    assign sync_level = pins_sync[0];
    assign pll_level = pins_sync[1];
    assign wr_status = WR && (ADDR == ADDR_STATUS);

    // Live status byte; reserved bits read zero.
    always_comb begin
        status_byte = RESET_BYTE;
        status_byte[BIT_LINK_UP] = LINK_UP;
        status_byte[BIT_SYNC] = sync_level;
        status_byte[BIT_REALIGNED] = state.realigned;
        status_byte[BIT_MULTIFRAME_FLAG_A] = state.multiframe_flag_a;
        status_byte[BIT_PLL] = pll_level;
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // Register writes, sticky flags, read data and the frozen working copy.
    always_comb begin
        next_state = state;
        next_state.rd_data = RESET_BYTE;
        if (WR) begin
            unique case (ADDR)
                ADDR_TEST_SEL: next_state.test_sel = WDATA[4:0];
                ADDR_IDENT: next_state.ident = {WDATA[7:1], 1'b0};
                ADDR_EOF_SEL: next_state.eof_sel = WDATA[1:0];
                ADDR_CTRL: begin
                    next_state.ctrl_enable = WDATA[BIT_CTRL_ENABLE];
                    next_state.ctrl_8b10b = WDATA[BIT_CTRL_8B10B];
                end
                ADDR_IRQ_MASK: next_state.irq_mask = WDATA & STICKY_MASK;
                default: ;
            endcase
        end
        if (RD) begin
            unique case (ADDR)
                ADDR_TEST_SEL: next_state.rd_data = {3'h0, state.test_sel};
                ADDR_IDENT: next_state.rd_data = state.ident;
                ADDR_EOF_SEL: next_state.rd_data = {6'h00, state.eof_sel};
                ADDR_STATUS: next_state.rd_data = status_byte;
                ADDR_CTRL: next_state.rd_data = {6'h00, state.ctrl_8b10b, state.ctrl_enable};
                ADDR_IRQ_MASK: next_state.rd_data = state.irq_mask;
                default: next_state.rd_data = RESET_BYTE;
            endcase
        end
        // Writing one clears a sticky bit, but a same-cycle event wins.
        if (wr_status && WDATA[BIT_REALIGNED]) begin
            next_state.realigned = 1'b0;
        end
        if (SYSREF_REALIGN) begin
            next_state.realigned = 1'b1;
        end
        // Arm on the rising edge of the enable; the first SYSREF then marks alignment.
        next_state.enable_d = state.ctrl_enable;
        if (!state.ctrl_enable) begin
            next_state.armed = 1'b0;
        end else if (!state.enable_d) begin
            next_state.armed = 1'b1;
        end
        if (wr_status && WDATA[BIT_MULTIFRAME_FLAG_A]) begin
            next_state.multiframe_flag_a = 1'b0;
        end
        if (state.armed && SYSREF_EVENT) begin
            next_state.multiframe_flag_a = 1'b1;
            next_state.armed = 1'b0;
        end
        // Pattern, word, identifiers and comma reach the lanes only while the link is disabled, so a stray write
        // to them during operation cannot corrupt a running frame; the 8b/10b bit still gates EOF.enable and EOF.insert live.
        if (!state.ctrl_enable) begin
            next_state.eff_mode = decode_pattern(state.test_sel, state.ctrl_8b10b);
            next_state.eff_word = static_word(next_state.eff_mode);
            next_state.eff_static = (next_state.eff_mode == PAT_HOLD_LOW)
                || (next_state.eff_mode == PAT_HOLD_HIGH) || (next_state.eff_mode == PAT_CLOCK);
            next_state.eff_ident = state.ident;
            next_state.eff_ident_b = state.ident + 8'h01;
            next_state.eff_char = eof_char(state.eof_sel);
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Single synchronous reset brings every field to its documented default.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state <= '0;
            state.eff_char <= CHAR_K28_7;
            state.eff_ident_b <= RESET_BYTE + 8'h01;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Lane controls and alignment identifiers come straight from flip-flops; ILA.valid is decoded from the far-side inputs.
    assign RDATA = state.rd_data;
    assign LINK_ENABLE = state.ctrl_enable;
    assign LANE_PATTERN = state.eff_mode;
    assign LANE_STATIC = state.eff_static;
    assign LANE_WORD = state.eff_word;
    assign ILA = '{
        ident_a: state.eff_ident,
        ident_b: state.eff_ident_b,
        valid: ILA_ACTIVE && (ILA_MULTIFRAME == ILA_IDENT_MF)
    };

    // The comma is only substituted where the framer says a frame end may carry it.
    assign EOF = '{
        char_code: state.eff_char,
        enable: state.ctrl_enable && state.ctrl_8b10b,
        insert: state.ctrl_enable && state.ctrl_8b10b && FRAME_END_OK
    };

    // Level interrupt while any unmasked sticky bit is set.
    assign IRQ = |({3'h0, state.realigned, state.multiframe_flag_a, 3'h0} & state.irq_mask);

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    chk_zero_normal: assert property (
        (state.test_sel == 5'h00 && !state.ctrl_enable) |=> LANE_PATTERN == PAT_NORMAL)
        else $error("Selector zero did not give normal samples.");
    chk_prbs_decode: assert property (
        (state.test_sel == 5'h0D && !state.ctrl_enable) |=> LANE_PATTERN == PAT_PRBS9)
        else $error("PRBS9 selector decoded wrongly.");
    chk_ramp_decode: assert property (
        (state.test_sel == 5'h04 && !state.ctrl_enable) |=> LANE_PATTERN == PAT_RAMP)
        else $error("Ramp selector decoded wrongly.");
    chk_k_mode_gate: assert property (
        (state.test_sel == 5'h10 && !state.ctrl_enable)
        |=> LANE_PATTERN == ($past(state.ctrl_8b10b) ? PAT_K28_7 : PAT_NORMAL))
        else $error("K28.7 mode not gated by line encoding.");
    chk_hold_high: assert property (
        (LANE_PATTERN == PAT_HOLD_HIGH) |-> (LANE_STATIC && LANE_WORD == WORD_HIGH))
        else $error("Held-high pattern does not drive all ones.");
    chk_clock_word: assert property (
        (LANE_PATTERN == PAT_CLOCK) |-> (LANE_STATIC && LANE_WORD == WORD_CLOCK))
        else $error("Clock pattern word is wrong.");
    chk_ident_pair: assert property (
        ILA.ident_b == ILA.ident_a + 8'h01)
        else $error("Link B identifier is not link A plus one.");
    chk_ident_even: assert property (
        (RD && ADDR == ADDR_IDENT) |=> RDATA[0] == 1'b0)
        else $error("Identifier bit zero read back as one.");
    chk_eof_char: assert property (
        (state.eof_sel == 2'h1 && !state.ctrl_enable) |=> EOF.char_code == CHAR_K28_1)
        else $error("Comma select one did not give K28.1.");
    chk_eof_gate: assert property (
        EOF.insert |-> (state.ctrl_8b10b && FRAME_END_OK))
        else $error("Comma inserted outside 8b/10b or off a frame end.");
    chk_realign_set: assert property (
        SYSREF_REALIGN |=> state.realigned)
        else $error("Realign event lost.");
    chk_multiframe_flag_a_once: assert property (
        (state.armed && SYSREF_EVENT) |=> (state.multiframe_flag_a && !state.armed))
        else $error("First SYSREF after enable did not mark alignment.");
    chk_status_read: assert property (
        (RD && ADDR == ADDR_STATUS) |=> RDATA[BIT_SYNC] == $past(sync_level))
        else $error("Sync level not reported in status.");
    chk_reserved_sel: assert property (
        (state.test_sel == 5'h0C && !state.ctrl_enable) |=> LANE_PATTERN == PAT_NORMAL)
        else $error("Reserved selector left normal transmission.");
    // Further decodes, frozen lane settings and the status bits.
    chk_hold_low: assert property (
        (LANE_PATTERN == PAT_HOLD_LOW) |-> (LANE_STATIC && LANE_WORD == WORD_LOW))
        else $error("Held-low pattern does not drive all zeros.");
    chk_prbs7_decode: assert property (
        (state.test_sel == 5'h01 && !state.ctrl_enable) |=> LANE_PATTERN == PAT_PRBS7)
        else $error("PRBS7 selector decoded wrongly.");
    chk_prbs31_decode: assert property (
        (state.test_sel == 5'h0E && !state.ctrl_enable) |=> LANE_PATTERN == PAT_PRBS31)
        else $error("PRBS31 selector decoded wrongly.");
    chk_transport_decode: assert property (
        (state.test_sel == 5'h05 && !state.ctrl_enable) |=> LANE_PATTERN == PAT_TRANSPORT)
        else $error("Transport selector decoded wrongly.");
    chk_d21_decode: assert property (
        (state.test_sel == 5'h06 && !state.ctrl_enable) |=> LANE_PATTERN == PAT_D21_5)
        else $error("D21.5 selector decoded wrongly.");
    chk_k28_5_gate: assert property (
        (state.test_sel == 5'h07 && !state.ctrl_enable)
        |=> LANE_PATTERN == ($past(state.ctrl_8b10b) ? PAT_K28_5 : PAT_NORMAL))
        else $error("K28.5 mode not gated by line encoding.");
    chk_upper_reserved: assert property (
        (state.test_sel > 5'h10 && !state.ctrl_enable) |=> LANE_PATTERN == PAT_NORMAL)
        else $error("Upper reserved selector left normal transmission.");
    chk_frozen_lanes: assert property (
        state.ctrl_enable |=> $stable({LANE_PATTERN, LANE_WORD, ILA.ident_a, ILA.ident_b, EOF.char_code}))
        else $error("Lane settings changed while the link was enabled.");
    chk_eof_k28_5: assert property (
        (state.eof_sel == 2'h2 && !state.ctrl_enable) |=> EOF.char_code == CHAR_K28_5)
        else $error("Comma select two did not give K28.5.");
    chk_eof_reserved: assert property (
        (state.eof_sel == 2'h3 && !state.ctrl_enable) |=> EOF.char_code == CHAR_K28_7)
        else $error("Reserved comma select did not fall back to K28.7.");
    chk_eof_encoding: assert property (
        !state.ctrl_8b10b |-> !EOF.enable)
        else $error("Comma insertion enabled outside 8b/10b.");
    chk_link_up_read: assert property (
        (RD && ADDR == ADDR_STATUS) |=> RDATA[BIT_LINK_UP] == $past(LINK_UP))
        else $error("Link up not reported in status.");
    chk_pll_read: assert property (
        (RD && ADDR == ADDR_STATUS) |=> RDATA[BIT_PLL] == $past(pll_level))
        else $error("PLL lock not reported in status.");
    chk_realign_clear: assert property (
        (wr_status && WDATA[BIT_REALIGNED] && !SYSREF_REALIGN) |=> !state.realigned)
        else $error("Realign bit not cleared by writing one.");
    chk_multiframe_flag_a_clear: assert property (
        (wr_status && WDATA[BIT_MULTIFRAME_FLAG_A] && !(state.armed && SYSREF_EVENT)) |=> !state.multiframe_flag_a)
        else $error("Multiframe_flag_a bit not cleared by writing one.");
    chk_unarmed_ignore: assert property (
        (!state.armed && !state.multiframe_flag_a) |=> !state.multiframe_flag_a)
        else $error("Multiframe_flag_a bit set without an armed SYSREF.");

    cov_prbs31: cover property (LANE_PATTERN == PAT_PRBS31);
    cov_multiframe_flag_a_irq: cover property (state.multiframe_flag_a && IRQ);
    cov_eof_insert: cover property (EOF.insert && EOF.char_code == CHAR_K28_5);
    cov_clear_race: cover property (wr_status && WDATA[BIT_REALIGNED] && SYSREF_REALIGN);
    cov_frozen_write: cover property (WR && ADDR == ADDR_IDENT && state.ctrl_enable);

endmodule : slt_bank

// File: slt_pkg.sv
// Package for the serial link test and alignment configuration bank.
// Assumes one 25 MHz clock and a plain register port with 10-bit byte addresses.
package slt_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [9:0] ADDR_TEST_SEL = 10'h205;
    localparam logic [9:0] ADDR_IDENT = 10'h206;
    localparam logic [9:0] ADDR_EOF_SEL = 10'h207;
    localparam logic [9:0] ADDR_STATUS = 10'h208;
    localparam logic [9:0] ADDR_CTRL = 10'h210;
    localparam logic [9:0] ADDR_IRQ_MASK = 10'h211;
    localparam int BIT_LINK_UP = 6;
    localparam int BIT_SYNC = 5;
    localparam int BIT_REALIGNED = 4;
    localparam int BIT_MULTIFRAME_FLAG_A = 3;
    localparam int BIT_PLL = 2;
    localparam int BIT_CTRL_ENABLE = 0;
    localparam int BIT_CTRL_8B10B = 1;
    localparam logic [7:0] STICKY_MASK = 8'h18;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] ILA_IDENT_MF = 2'h1;

    // ************************************************************
    // Lane patterns and characters
    // ************************************************************
    typedef enum logic [4:0] {
        PAT_NORMAL = 5'h00, PAT_PRBS7 = 5'h01, PAT_PRBS15 = 5'h02, PAT_PRBS23 = 5'h03,
        PAT_RAMP = 5'h04, PAT_TRANSPORT = 5'h05, PAT_D21_5 = 5'h06, PAT_K28_5 = 5'h07,
        PAT_REPEAT_ILA = 5'h08, PAT_MOD_RPAT = 5'h09, PAT_HOLD_LOW = 5'h0A,
        PAT_HOLD_HIGH = 5'h0B, PAT_PRBS9 = 5'h0D, PAT_PRBS31 = 5'h0E,
        PAT_CLOCK = 5'h0F, PAT_K28_7 = 5'h10
    } slt_pattern_t;

    localparam logic [15:0] WORD_LOW = 16'h0000;
    localparam logic [15:0] WORD_HIGH = 16'hFFFF;
    localparam logic [15:0] WORD_CLOCK = 16'h00FF;
    localparam logic [7:0] CHAR_K28_7 = 8'hFC;
    localparam logic [7:0] CHAR_K28_1 = 8'h3C;
    localparam logic [7:0] CHAR_K28_5 = 8'hBC;

    // ************************************************************
    // Carriers and state
    // ************************************************************
    typedef struct packed {
        logic [7:0] ident_a;
        logic [7:0] ident_b;
        logic valid;
    } slt_ila_t;

    typedef struct packed {
        logic [7:0] char_code;
        logic enable;
        logic insert;
    } slt_eof_t;

    typedef struct packed {
        logic [4:0] test_sel;
        logic [7:0] ident;
        logic [1:0] eof_sel;
        logic ctrl_enable;
        logic ctrl_8b10b;
        logic [7:0] irq_mask;
        logic realigned;
        logic multiframe_flag_a;
        logic armed;
        logic enable_d;
        slt_pattern_t eff_mode;
        logic [15:0] eff_word;
        logic eff_static;
        logic [7:0] eff_ident;
        logic [7:0] eff_ident_b;
        logic [7:0] eff_char;
        logic [7:0] rd_data;
    } slt_state_t;

    typedef struct packed {
        logic [1:0] first;
        logic [1:0] second;
    } slt_sync_t;

endpackage : slt_pkg

// File: slt_sync.sv
// Two-stage synchroniser for the sync request and PLL lock pins.
// Assumes both pins are asynchronous levels; pulses shorter than one clock may be missed.
`timescale 1ns/1ps
module slt_sync (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [1:0] PIN_IN,
    output logic [1:0] PIN_OUT
);
    import slt_pkg::*;

    slt_sync_t state;
    slt_sync_t next_state;

    // The first stage feeds only the second stage to keep metastability contained.
    always_comb begin
        next_state = state;
        next_state.first = PIN_IN;
        next_state.second = state.first;
    end

    // Reset parks both stages low, which reads as sync asserted and PLL unlocked.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign PIN_OUT = state.second;

endmodule : slt_sync

// File: slt_far_model.sv
// Far-side stand-in: ILA sequencer, framer and link monitor facing the bank.
// Assumes everything runs on CLOCK and that the bank's LINK_ENABLE starts the link.
`timescale 1ns/1ps
module slt_far_model (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic LINK_ENABLE,
    output logic LINK_UP,
    output logic ILA_ACTIVE,
    output logic [1:0] ILA_MULTIFRAME,
    output logic FRAME_END_OK
);
    // ************************************************************
    // Alignment sequence and frame ends
    // ************************************************************
    logic [3:0] ila_count;

    // Four multiframes of two cycles, then the link stays up until disabled.
    // Frame-end openings alternate so that insertion is seen both allowed and withheld.
    always_ff @(posedge CLOCK) begin
        if (RESET || !LINK_ENABLE) begin
            ila_count <= 4'h0;
            FRAME_END_OK <= 1'b0;
        end else begin
            if (!ila_count[3]) begin
                ila_count <= ila_count + 4'h1;
            end
            FRAME_END_OK <= !FRAME_END_OK;
        end
    end

    // The second multiframe is where the identifier travels.
    assign ILA_ACTIVE = LINK_ENABLE && !ila_count[3];
    assign ILA_MULTIFRAME = ila_count[2:1];
    assign LINK_UP = LINK_ENABLE && ila_count[3];
endmodule : slt_far_model

// File: slt_bank_test.sv
// Self-checking bench for the serial link test and alignment register bank.
// Assumes slt_pkg and the far-side model are compiled first.
`timescale 1ns/1ps
module slt_bank_test;
    import slt_pkg::*;
    logic CLOCK, RESET, WR, RD, SYNC_N_PIN, PLL_LOCK_PIN, SYSREF_REALIGN, SYSREF_EVENT;
    logic [9:0] ADDR;
    logic [7:0] WDATA, RDATA;
    logic LINK_UP, ILA_ACTIVE, FRAME_END_OK, LINK_ENABLE, LANE_STATIC, IRQ;
    logic [1:0] ILA_MULTIFRAME;
    logic [15:0] LANE_WORD;
    slt_pattern_t LANE_PATTERN;
    slt_ila_t ILA;
    slt_eof_t EOF;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] got;

    slt_bank DUT (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .LINK_UP(LINK_UP), .SYNC_N_PIN(SYNC_N_PIN), .PLL_LOCK_PIN(PLL_LOCK_PIN),
        .SYSREF_REALIGN(SYSREF_REALIGN), .SYSREF_EVENT(SYSREF_EVENT), .ILA_ACTIVE(ILA_ACTIVE),
        .ILA_MULTIFRAME(ILA_MULTIFRAME), .FRAME_END_OK(FRAME_END_OK), .LINK_ENABLE(LINK_ENABLE),
        .LANE_PATTERN(LANE_PATTERN), .LANE_STATIC(LANE_STATIC), .LANE_WORD(LANE_WORD), .ILA(ILA),
        .EOF(EOF), .IRQ(IRQ));
    slt_far_model FAR (.CLOCK(CLOCK), .RESET(RESET), .LINK_ENABLE(LINK_ENABLE), .LINK_UP(LINK_UP),
        .ILA_ACTIVE(ILA_ACTIVE), .ILA_MULTIFRAME(ILA_MULTIFRAME), .FRAME_END_OK(FRAME_END_OK));

    // ************************************************************
    // Clock, timeout and shared tasks
    // ************************************************************
    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end

    // A hang anywhere ends the run as a failure once 5000 cycles are spent.
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("Checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] val, input logic [15:0] exp, input string what);
        check_count++;
        if (val !== exp) begin
            miscompares++;
            $display("FAIL at %0t: %s is %h, expected %h", $time, what, val, exp);
        end
    endtask : chk

    // Strobes are raised just after an edge and dropped after the edge that takes them.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [9:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        chk(RDATA & mask, exp, "read data");
    endtask : rdchk

    task automatic sysref(input bit realign);
        @(posedge CLOCK);
        if (realign)
            SYSREF_REALIGN <= 1'b1;
        else
            SYSREF_EVENT <= 1'b1;
        @(posedge CLOCK);
        SYSREF_REALIGN <= 1'b0;
        SYSREF_EVENT <= 1'b0;
        #1;
    endtask : sysref

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_reset;
        rdchk(10'h205, 8'hFF, 8'h00);
        rdchk(10'h206, 8'hFF, 8'h00);
        rdchk(10'h207, 8'hFF, 8'h00);
        rdchk(10'h208, 8'hFF, 8'h00);
        chk(EOF.char_code, 8'hFC, "reset comma");
        wr(10'h3FF, 8'hFF);
        rdchk(10'h3FF, 8'hFF, 8'h00);
        rdchk(10'h205, 8'hFF, 8'h00);
    endtask : test_reset

    // Every selector value in both encodings; 8b/10b-only and reserved codes fall back to samples.
    task automatic test_patterns;
        logic [4:0] e;
        for (int enc = 1; enc >= 0; enc--) begin
            wr(10'h210, enc ? 8'h02 : 8'h00);
            for (int v = 0; v < 32; v++) begin
                wr(10'h205, 8'(v));
                rdchk(10'h205, 8'h1F, 8'(v));
                e = (v == 12 || v > 16 || (enc == 0 && v inside {7, 8, 9, 16})) ? 5'h00 : 5'(v);
                chk(LANE_PATTERN, e, "lane pattern");
                chk(LANE_STATIC, e inside {5'h0A, 5'h0B, 5'h0F}, "static");
                chk(LANE_WORD, e == 5'h0B ? 16'hFFFF : (e == 5'h0F ? 16'h00FF : 16'h0000), "word");
            end
        end
    endtask : test_patterns

    task automatic test_ident;
        wr(10'h210, 8'h02);
        wr(10'h206, 8'h35);
        rdchk(10'h206, 8'hFF, 8'h34);
        @(posedge CLOCK);
        #1;
        chk(RDATA, 8'h00, "idle read data");
        wr(10'h210, 8'h03);
        for (int i = 0; i < 20 && ILA.valid !== 1'b1; i++)
            @(posedge CLOCK);
        #1;
        chk(ILA.valid, 1'b1, "ila valid");
        chk({ILA.ident_a, ILA.ident_b}, 16'h3435, "idents");
        repeat (10) @(posedge CLOCK);
        #1;
        chk(ILA.valid, 1'b0, "ila over");
        rdchk(10'h208, 8'hE4, 8'h64);
        wr(10'h206, 8'h10);
        rdchk(10'h206, 8'hFF, 8'h10);
        chk(ILA.ident_a, 8'h34, "frozen ident");
        wr(10'h210, 8'h02);
        repeat (2) @(posedge CLOCK);
        #1;
        chk({ILA.ident_a, ILA.ident_b}, 16'h1011, "new idents");
    endtask : test_ident

    task automatic test_eof;
        logic [7:0] codes [4] = '{8'hFC, 8'h3C, 8'hBC, 8'hFC};
        for (int s = 0; s < 4; s++) begin
            wr(10'h207, 8'(s));
            rdchk(10'h207, 8'h03, 8'(s));
            chk(EOF.char_code, codes[s], "comma code");
            chk(EOF.enable, 1'b0, "comma off while disabled");
        end
        wr(10'h207, 8'h02);
        wr(10'h210, 8'h03);
        @(posedge FRAME_END_OK);
        #1;
        chk({EOF.enable, EOF.insert, EOF.char_code}, {2'b11, 8'hBC}, "comma insert");
        @(posedge CLOCK);
        #1;
        chk(EOF.insert, 1'b0, "no frame end");
        wr(10'h210, 8'h01);
        @(posedge CLOCK);
        #1;
        chk(EOF.enable, 1'b0, "comma off in 64b66b");
        wr(10'h210, 8'h00);
    endtask : test_eof

    task automatic test_status;
        wr(10'h211, 8'hFF);
        rdchk(10'h211, 8'hFF, 8'h18);
        sysref(1'b1);
        chk(IRQ, 1'b1, "irq on realign");
        rdchk(10'h208, 8'hFF, 8'h34);
        wr(10'h208, 8'h10);
        rdchk(10'h208, 8'hFF, 8'h24);
        chk(IRQ, 1'b0, "irq cleared");
        wr(10'h211, 8'h08);
        sysref(1'b1);
        chk(IRQ, 1'b0, "irq masked");
        wr(10'h208, 8'h10);
        sysref(1'b0);
        rdchk(10'h208, 8'h08, 8'h00);
        wr(10'h210, 8'h03);
        sysref(1'b0);
        chk(IRQ, 1'b1, "irq on multiframe_flag_a");
        rdchk(10'h208, 8'h18, 8'h08);
        wr(10'h208, 8'h08);
        sysref(1'b0);
        rdchk(10'h208, 8'h08, 8'h00);
        chk(IRQ, 1'b0, "second event ignored");
        // A clear that lands together with a new realign event must leave the bit set.
        @(posedge CLOCK);
        ADDR <= 10'h208;
        WDATA <= 8'h10;
        WR <= 1'b1;
        SYSREF_REALIGN <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        SYSREF_REALIGN <= 1'b0;
        rdchk(10'h208, 8'h10, 8'h10);
        wr(10'h208, 8'h10);
        wr(10'h210, 8'h00);
    endtask : test_status

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        RESET = 1'b1;
        {WR, RD, SYNC_N_PIN, PLL_LOCK_PIN, SYSREF_REALIGN, SYSREF_EVENT} = 6'h00;
        ADDR = 10'h000;
        WDATA = 8'h00;
        repeat (2) @(posedge CLOCK);
        RESET <= 1'b0;
        test_reset();
        SYNC_N_PIN <= 1'b1;
        PLL_LOCK_PIN <= 1'b1;
        test_patterns();
        test_ident();
        test_eof();
        test_status();
        report_and_stop();
    end
endmodule : slt_bank_test
